// file: serial_sar_adc_frame_control.sv
`timescale 1ns/1ps
module serial_sar_adc_frame_control #(
  parameter int RES_BITS  = sar_adc_pkg::RES_DEFAULT,
  parameter bit DUAL_CHAN = 1'b1
) (
  // clock and reset
  input  wire logic                     ref_clk,
  input  wire logic                     rst_n,
  // serial link pins
  input  wire logic                     csN,
  input  wire logic                     sclk,
  input  wire logic                     channelPick,
  output logic                          dataOut,
  output logic                          dataOutEn,
  // analog inputs as digitised fractions of the reference span
  input  wire sar_adc_pkg::analog_pair_s analogIn,
  // status
  output logic                          powered,
  output sar_adc_pkg::adc_result_s      result,
  output logic                          resultStrobe
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync;
  logic       rstSyncN;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end

  assign rstSyncN = rstSync[1];

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] pinLevel;
  logic [2:0] pinRise;
  logic [2:0] pinFall;

  pin_sync #(
    .W       (3),
    .RST_VAL (3'h5)
  ) u_pin_sync (
    .clk   (ref_clk),
    .rstN  (rstSyncN),
    .pinIn ({csN, channelPick, sclk}),
    .level (pinLevel),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  logic csLevel;
  logic csFall;
  logic csRise;
  logic pickLevel;
  logic sclkFall;

  assign csLevel   = pinLevel[2];
  assign csFall    = pinFall[2];
  assign csRise    = pinRise[2];
  assign pickLevel = pinLevel[1];
  assign sclkFall  = pinFall[0];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // keep the trial bit when the sample lies at or above the trial
  // code minus half an LSB
  function automatic logic trialKeep(
    input logic [sar_adc_pkg::ANALOG_W-1:0] sample,
    input logic [sar_adc_pkg::RES_MAX-1:0]  trial
  );
    logic [sar_adc_pkg::ANALOG_W:0] level;
    logic [sar_adc_pkg::ANALOG_W:0] halfLsb;
    level     = {1'b0, sample};
    halfLsb   = (sar_adc_pkg::ANALOG_W+1)'(1) << (sar_adc_pkg::ANALOG_W - RES_BITS - 1);
    level     = level + halfLsb; // [R16]
    trialKeep = (level >> (sar_adc_pkg::ANALOG_W - RES_BITS)) >=
                (sar_adc_pkg::ANALOG_W+1)'(trial);
  endfunction : trialKeep

  // ----------------------------------------------------------------
  // frame state
  // ----------------------------------------------------------------
  sar_adc_pkg::adc_state_s stateReg;
  sar_adc_pkg::adc_state_s stateNext;

  logic [sar_adc_pkg::CNT_W-1:0]   fallNum;
  logic [sar_adc_pkg::RES_MAX-1:0] trialCode;
  logic                            bitKeep;
  int                              bitIdx;

  always_comb begin
    stateNext              = stateReg;
    stateNext.resultStrobe = 1'b0;
    fallNum                = stateReg.fallCnt + sar_adc_pkg::CNT_W'(1);
    bitIdx                 = RES_BITS - int'(fallNum);
    trialCode              = '0;
    bitKeep                = 1'b0;

    case (stateReg.phase)
      sar_adc_pkg::PH_IDLE: begin
        // serial clock edges are ignored while deselected
        if (csFall) begin
          stateNext.phase      = sar_adc_pkg::PH_FRAME; // [R1]
          stateNext.fallCnt    = '0;
          stateNext.sar        = '0;
          stateNext.sample     = (DUAL_CHAN && pickLevel) ? analogIn.second
                                                          : analogIn.first; // [R8]
          stateNext.dout       = 1'b0; // [R2]
          stateNext.doutEn     = 1'b1;
          stateNext.frameValid = stateReg.powered; // [R15]
        end
      end

      sar_adc_pkg::PH_FRAME: begin
        if (csRise) begin
          stateNext.phase = sar_adc_pkg::PH_IDLE;
          if (stateReg.fallCnt < sar_adc_pkg::MODE_DECIDE_FALL) begin
            stateNext.powered = 1'b0; // [R11]
            stateNext.doutEn  = 1'b0; // [R18]
          end else if (stateReg.fallCnt > sar_adc_pkg::SHORT_FALL) begin
            stateNext.doutEn = 1'b0; // [R18]
          end
          // short frames keep the trailing zero driven until reselected [R17]
          // ending after the tenth fall leaves power as it is [R10]
        end else if (sclkFall && stateReg.fallCnt < sar_adc_pkg::COUNT_CEIL) begin
          stateNext.fallCnt = fallNum;
          if (bitIdx >= 0) begin
            trialCode     = stateReg.sar | (sar_adc_pkg::RES_MAX'(1) << bitIdx);
            bitKeep       = trialKeep(stateReg.sample, trialCode);
            stateNext.sar = bitKeep ? trialCode : stateReg.sar; // [R5]
            stateNext.dout = bitKeep; // [R3] [R4]
          end else begin
            stateNext.dout = 1'b0; // [R2]
          end
          if (bitIdx == 0) begin
            stateNext.result.valid = stateReg.frameValid; // [R13]
            stateNext.result.code  = bitKeep ? trialCode : stateReg.sar;
            stateNext.resultStrobe = 1'b1;
          end
          if (fallNum == sar_adc_pkg::MODE_DECIDE_FALL) begin
            // wake completes with the dummy frame, so it tracks the clock rate
            stateNext.powered = 1'b1; // [R13] [R14]
          end
          if (fallNum == sar_adc_pkg::RELEASE_FALL) begin
            stateNext.doutEn = 1'b0; // [R6]
          end
        end
      end

      default: begin
        stateNext.phase  = sar_adc_pkg::PH_IDLE;
        stateNext.doutEn = 1'b0;
      end
    endcase

    // a glitch may leave the frame open with the pin high; close it
    if (stateReg.phase == sar_adc_pkg::PH_FRAME && csLevel && !csRise) begin
      stateNext.phase  = sar_adc_pkg::PH_IDLE;
      stateNext.doutEn = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      stateReg              <= '0;
      stateReg.phase        <= sar_adc_pkg::PH_IDLE;
      stateReg.powered      <= 1'b1;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dataOut      = stateReg.dout;
  assign dataOutEn    = stateReg.doutEn;
  assign powered      = stateReg.powered;
  assign result       = stateReg.result;
  assign resultStrobe = stateReg.resultStrobe;

endmodule : serial_sar_adc_frame_control

// file: sar_adc_pkg.sv
// Functional notes
// R1: chip-select fall samples input, starts conversion, opens a new output frame.
// R2: frame is one leading zero, result MSB first, then trailing zeros.
// R3: serial data output changes only on serial clock falling edges; the code also sets the leading zero on chip-select fall.
// R4: MSB in cycle 2, LSB in cycle 13, 11 or 9 by resolution.
// R5: one binary-weighted bit resolved per serial clock cycle while selected.
// R6: data output released to high impedance during cycle 16.
// R7: host restarts after cycle 16 for full rate, later for lower rates.
// R8: channel pick high converts second input, low converts first input.
// R9: host changes channel pick only between cycles 2 and 12.
// R10: chip select rising after tenth falling edge keeps normal powered mode.
// R11: chip select rising before tenth falling edge aborts, floats output, powers down.
// R12: host requests power-down by rising between second and tenth falling edges.
// R13: dummy frame of ten or more cycles wakes; its data invalid, next valid.
// R14: wake time equals dummy frame length, scaling with serial clock period.
// R15: normal mode stays powered between frames, every frame valid.
// R16: straight binary code, transitions at half LSB, LSB is span over 2^n.
// R17: fourteen-cycle frames supported, output not floated between such frames.
// R18: with chip select high, serial clock ignored and output floats; the code keeps it driven after frames ending at falls 10 to 13.
package sar_adc_pkg;

  // ----------------------------------------------------------------
  // widths and frame timing
  // ----------------------------------------------------------------
  localparam int          ANALOG_W        = 16;
  localparam int          RES_MAX         = 12;
  localparam int          CNT_W           = 5;
  localparam int          RES_DEFAULT     = 12;
  localparam logic [4:0]  MODE_DECIDE_FALL = 5'h0A;
  localparam logic [4:0]  RELEASE_FALL    = 5'h0F;
  localparam logic [4:0]  SHORT_FALL      = 5'h0D;
  localparam logic [4:0]  COUNT_CEIL      = 5'h10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b01,
    PH_FRAME = 2'b10
  } phase_e;

  typedef struct packed {
    logic [ANALOG_W-1:0] first;
    logic [ANALOG_W-1:0] second;
  } analog_pair_s;

  typedef struct packed {
    logic               valid;
    logic [RES_MAX-1:0] code;
  } adc_result_s;

  typedef struct packed {
    phase_e              phase;
    logic [CNT_W-1:0]    fallCnt;
    logic [ANALOG_W-1:0] sample;
    logic [RES_MAX-1:0]  sar;
    logic                dout;
    logic                doutEn;
    logic                powered;
    logic                frameValid;
    adc_result_s         result;
    logic                resultStrobe;
  } adc_state_s;

endpackage : sar_adc_pkg

// file: pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int         W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rstN,
  // pins
  input  wire logic [W-1:0] pinIn,
  // synchronised level and edges
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
    logic [W-1:0] last;
  } sync_s;

  sync_s stateReg;
  sync_s stateNext;

  // ----------------------------------------------------------------
  // two-stage sync plus one stage for edge detection
  // ----------------------------------------------------------------
  always_comb begin
    stateNext        = stateReg;
    stateNext.meta   = pinIn;
    stateNext.stable = stateReg.meta;
    stateNext.last   = stateReg.stable;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stateReg <= {RST_VAL, RST_VAL, RST_VAL};
    end else begin
      stateReg <= stateNext;
    end
  end

  assign level = stateReg.stable;
  assign rise  = stateReg.stable & ~stateReg.last;
  assign fall  = ~stateReg.stable & stateReg.last;

endmodule : pin_sync

// file: adc_frame_asserts.sv
`timescale 1ns/1ps
module adc_frame_asserts #(
  parameter int RES_BITS = 12
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // link and status
  input wire logic csN,
  input wire logic sclk,
  input wire logic dataOut,
  input wire logic dataOutEn,
  input wire logic powered,
  input wire logic resultStrobe
);
  // ----------------------------------------------------------------
  // raw fall count, runs two edges ahead of the synchronised copy
  // ----------------------------------------------------------------
  logic       sclkQ_reg;
  logic       csQ_reg;
  logic [4:0] fc_reg;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclkQ_reg <= 1'b1;
      csQ_reg   <= 1'b1;
      fc_reg    <= 5'h0;
    end else begin
      sclkQ_reg <= sclk;
      csQ_reg   <= csN;
      if (csQ_reg && !csN) begin
        fc_reg <= 5'h0;
      end else if (!csN && sclkQ_reg && !sclk && fc_reg != 5'h1F) begin
        fc_reg <= fc_reg + 5'h1;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_frame_open: assert property (
    $fell(csN) |-> ##[2:6] (dataOutEn && !dataOut)) else $error("frame not opened");
  a_data_edge: assert property (
    $changed(dataOut) && dataOutEn && $past(dataOutEn) |-> !$past(sclk, 3) && $past(sclk, 5))
    else $error("data moved off a clock fall");
  a_float_late: assert property (
    $rose(fc_reg == 5'h0F) |-> ##[1:6] !dataOutEn) else $error("no release in cycle 16");
  a_power_down: assert property (
    $rose(csN) && fc_reg >= 5'h2 && fc_reg < 5'hA |-> ##[2:8] (!powered && !dataOutEn))
    else $error("early rise did not power down");
  a_normal_keep: assert property (
    $rose(csN) && fc_reg >= 5'hA |-> ##6 powered) else $error("late rise lost power");
  a_idle_float: assert property (
    csN && $past(csN, 6) && !$past(dataOutEn) |-> !dataOutEn) else $error("driven while idle");
  a_wake_dummy: assert property (
    $rose(powered) |-> !csN && fc_reg >= 5'hA) else $error("woke before tenth fall");
  a_strobe_pulse: assert property (
    resultStrobe |=> !resultStrobe) else $error("strobe too long");
  a_strobe_count: assert property (
    resultStrobe |-> fc_reg == 5'(RES_BITS)) else $error("strobe at wrong fall");
endmodule : adc_frame_asserts

// file: spi_host.sv
`timescale 1ns/1ps
module spi_host (
  // timing reference and sensed data wire
  input wire logic clk,
  input wire logic dWire,
  // link
  output logic     csN,
  output logic     sclk
);
  // clock rests high between frames except while idleClocks pulses it; 13 ns offset keeps it off the ref edges
  initial begin
    csN  = 1'b1;
    sclk = 1'b1;
  end
  task automatic frame(input int n, output logic [15:0] bits);
    bits = 'x;
    @(negedge clk);
    #13 csN = 1'b0; // clock held high at select
    #200;
    for (int k = 0; k < n; k++) begin
      bits[15-k] = dWire;
      sclk = 1'b0;
      #100 sclk = 1'b1;
      #100;
    end
    if (n < 16) bits[15-n] = dWire;
    csN = 1'b1; // rise after fall n, early n requests power-down
    #200; // next frame may start right after
  endtask : frame
  task automatic idleClocks();
    repeat (4) begin
      #100 sclk = 1'b0;
      #100 sclk = 1'b1;
    end
  endtask : idleClocks
endmodule : spi_host

// file: serial_sar_adc_frame_control_tb.sv
`timescale 1ns/1ps
module serial_sar_adc_frame_control_tb;
  typedef struct packed {logic [15:0] a; logic [15:0] b; logic pick; logic [11:0] c;} row_s;
  logic clk, rstN, csN, sclk, channelPick, dataOut, dataOutEn, powered, resultStrobe, dWire;
  sar_adc_pkg::analog_pair_s analogIn;
  sar_adc_pkg::adc_result_s  result;
  int          nMismatch;
  int          totalChecks;
  logic [15:0] bits;
  row_s        rows [4] = '{'{16'h0000, 16'hFFFF, 1'b0, 12'h000},
                            '{16'h0000, 16'hFFFF, 1'b1, 12'hFFF},
                            '{16'h1238, 16'h0000, 1'b0, 12'h124},
                            '{16'hC000, 16'h7FF7, 1'b1, 12'h7FF}};
  assign dWire = dataOutEn ? dataOut : 1'bz;
  spi_host host (.clk(clk), .dWire(dWire), .csN(csN), .sclk(sclk));
  serial_sar_adc_frame_control #(.RES_BITS(12), .DUAL_CHAN(1'b1)) uut (
    .ref_clk(clk), .rst_n(rstN), .csN(csN), .sclk(sclk), .channelPick(channelPick),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .analogIn(analogIn), .powered(powered),
    .result(result), .resultStrobe(resultStrobe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    totalChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic runFrame(input row_s r, input logic vld);
    @(negedge clk);
    analogIn = {r.a, r.b};
    channelPick = r.pick;
    host.frame(16, bits);
    check(bits, {1'b0, r.c, 2'h0, 1'bz});
    check({3'h0, result}, {3'h0, vld, r.c});
  endtask : runFrame
  // ----------------------------------------------------------------
  // main sequence: table rows, then power and short-frame cases
  // ----------------------------------------------------------------
  initial begin
    nMismatch = 0;
    totalChecks = 0;
    rstN = 1'b0;
    channelPick = 1'b0;
    analogIn = '0;
    repeat (10) @(negedge clk);
    check({3'h0, result}, 16'h0);
    rstN = 1'b1;
    repeat (8) @(negedge clk);
    check({14'h0, powered, dataOutEn}, 16'h2);
    foreach (rows[i]) runFrame(rows[i], 1'b1);
    host.idleClocks();
    check({15'h0, dataOutEn}, 16'h0);
    runFrame(rows[2], 1'b1);
    host.frame(5, bits);
    check({14'h0, powered, dataOutEn}, 16'h0);
    runFrame(rows[3], 1'b0);
    check({15'h0, powered}, 16'h1);
    runFrame(rows[1], 1'b1);
    @(negedge clk);
    analogIn = {rows[2].a, rows[2].b};
    channelPick = rows[2].pick;
    host.frame(13, bits);
    check({2'h0, bits[15:2]}, {3'h0, rows[2].c, 1'h0});
    check({14'h0, powered, dataOutEn}, 16'h3);
    runFrame(rows[0], 1'b1);
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    end_sim();
  end
endmodule : serial_sar_adc_frame_control_tb
bind serial_sar_adc_frame_control adc_frame_asserts #(.RES_BITS(RES_BITS)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .csN(csN), .sclk(sclk), .dataOut(dataOut),
  .dataOutEn(dataOutEn), .powered(powered), .resultStrobe(resultStrobe));
